// File: uecr_engine_model.sv
// Engine stand-in that sends an armed packet after a delay
`timescale 1ns/100ps
module uecr_engine_model
#(
   parameter int DELAY = 6 // One less than the cycles from arm to sent
)
(
   input wire logic clk_sys, // Clock
   input wire logic rst, // Reset
   input wire logic ep1_tx_armed, // Packet armed
   output logic tx_done // Packet sent pulse
);
   int cnt;
   // Sends only while armed; one done pulse per packet
   always_ff @(posedge clk_sys)
   begin
      tx_done <= 1'b0;
      if (rst || !ep1_tx_armed || tx_done)
         cnt <= 0;
      else if (cnt == DELAY)
         tx_done <= 1'b1;
      else
         cnt <= cnt + 1;
   end
endmodule

// File: uecr_fill_count.sv
// Byte count of one bulk buffer fill, cleared when a qualified write selects the buffer
`timescale 1ns/100ps
module uecr_fill_count
   import uecr_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic ce, // Clock enable
   input wire logic clr, // Buffer selected by qualified write, restart count
   input wire logic byte_in, // One byte stored in this buffer
   output logic [UECR_CNT_W-1:0] count_q // Bytes of latest fill
);
   typedef struct packed {logic [UECR_CNT_W-1:0] cnt;} uecr_cnt_s;
   uecr_cnt_s s_q, s_d;

   // Saturate at a full buffer; 512 needs the tenth bit
   always_comb
   begin
      s_d = s_q;
      if (clr)
         s_d.cnt = UECR_CNT_ZERO;
      else if (byte_in && s_q.cnt != UECR_CNT_W'(UECR_BUF_BYTES))
         s_d.cnt = s_q.cnt + 10'h001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_q <= '0;
      else if (ce)
         s_q <= s_d;
   end

   assign count_q = s_q.cnt;
endmodule

// File: uecr_pkg.sv
// Package with offsets, bit positions and reset values of the endpoint control bank
package uecr_pkg;
   localparam logic [7:0] UECR_OFS_EP1_RX = 8'hB2;
   localparam logic [7:0] UECR_OFS_EP1_TX = 8'hB3;
   localparam logic [7:0] UECR_OFS_EP2 = 8'hB4;
   localparam logic [7:0] UECR_RST_VAL = 8'h00;
   localparam int UECR_RX_ENABLE = 0;
   localparam int UECR_RX_STALL = 2;
   localparam int UECR_RX_TOGGLE = 3;
   localparam int UECR_TX_ENABLE = 0;
   localparam int UECR_TX_STALL = 2;
   localparam int UECR_TX_ARM = 4;
   localparam int UECR_EP2_SEL = 5;
   localparam int UECR_EP2_QUAL = 6;
   localparam int UECR_EP2_DIR = 7;
   localparam int UECR_BUF_BYTES = 512;
   localparam int UECR_CNT_W = 10;
   localparam logic [9:0] UECR_CNT_ZERO = 10'h000;
   // Handshake answers toward the serial engine
   typedef enum logic [1:0] {UECR_HS_ACK, UECR_HS_NAK, UECR_HS_STALL}
      uecr_hs_e;
endpackage

// File: uecr_regs.sv
// Endpoint one and bulk endpoint control registers with handshake choice
// How it works
// - Receive control bit 0 is firmware enable of endpoint one reception.
// - Reserved bits of both endpoint one registers read zero.
// - Writing one to transmit bit 4 arms the prepared packet for sending.
// - While endpoint one is armed, OUT tokens get a NAK.
// - The engine clears the arm bit when the packet is sent.
// - Transmit stall bit 2 makes IN tokens get a STALL.
// - Transmit stall is set by engine hardware or firmware writing one.
// - Clear feature for the endpoint or bus reset clears stalls.
// - Firmware writing zero to a stall bit leaves it unchanged.
// - Transmit bit 0 reads one when engine has transmission enabled.
// - Bulk control bit 7 picks direction, one is disk to engine.
// - Direction one and an OUT token on endpoint two flags error.
// - Direction zero and an IN token on endpoint two flags error.
// - Bit 5 is taken only when bit 6 of the written value is one.
// - The qualifier bit 6 always reads zero.
// - Qualified write of zero selects buffer A and clears its counts.
// - Qualified write of one selects buffer B and clears its counts.
// - Select bit reads the buffer being filled or filled last.
// - Each buffer keeps the byte count of its latest fill; only qualified writes clear a count, so fills by alternation add up.
// - With automatic alternation the select follows the filling buffer.
// - Receive stall bit 2 makes OUT tokens get a STALL.
// - Receive bit 3 shows the toggle of the last data packet.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module uecr_regs
   import uecr_pkg::*;
(
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic ce, // Clock enable, freezes all state
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic bus_reset, // USB bus reset seen
   input wire logic clear_feature_ep1, // Clear feature for endpoint one
   input wire logic tx_enabled, // Engine has endpoint one TX on
   input wire logic rx_stall_set, // Engine sets receive stall
   input wire logic tx_stall_set, // Engine sets transmit stall
   input wire logic tx_done, // Endpoint one packet sent
   input wire logic rx_data_valid, // Data packet received, endpoint one
   input wire logic rx_data_toggle, // Its data toggle
   input wire logic tok_valid, // Token arrived, one cycle
   input wire logic tok_in, // Token is IN, else OUT
   input wire logic tok_ep2, // Token for endpoint two, else one
   input wire logic auto_alt, // Automatic buffer alternation on
   input wire logic auto_sel_b, // Alternation filling buffer B
   input wire logic buf_byte, // Bulk byte stored in current buffer
   output logic ep1_rx_enable, // Endpoint one reception enabled
   output logic ep1_tx_armed, // Packet armed for sending
   output logic ep2_dir_to_host, // Bulk flow disk toward engine
   output logic buf_sel_b, // Filling buffer B, else A
   output logic hs_valid, // Handshake choice valid, one cycle
   output logic [1:0] hs_code, // Handshake for token, uecr_hs_e
   output logic bulk_direction_error, // Endpoint two direction error
   output logic [UECR_CNT_W-1:0] buf_a_count, // Buffer A fill count
   output logic [UECR_CNT_W-1:0] buf_b_count // Buffer B fill count
);
   typedef struct packed {
      logic rx_en;
      logic rx_tog;
      logic tx_arm;
      logic dir;
      logic sel;
      logic [7:0] rdata;
      logic hs_v;
      uecr_hs_e hs;
      logic err;
   } uecr_st_s;

   uecr_st_s s_q, s_d;
   logic rx_stall;
   logic tx_stall;
   logic stall_clr;
   logic wr_rx;
   logic wr_tx;
   logic wr_ep2;
   logic qual_wr;
   logic cur_sel;
   logic clr_a;
   logic clr_b;

   // Address decode of write strobes
   assign wr_rx = reg_wr && reg_addr == UECR_OFS_EP1_RX;
   assign wr_tx = reg_wr && reg_addr == UECR_OFS_EP1_TX;
   assign wr_ep2 = reg_wr && reg_addr == UECR_OFS_EP2;
   assign qual_wr = wr_ep2 && reg_wdata[UECR_EP2_QUAL];
   assign stall_clr = clear_feature_ep1 || bus_reset;
   // Firmware must not retarget mid-transfer; no guard is added here
   assign clr_a = qual_wr && !reg_wdata[UECR_EP2_SEL];
   assign clr_b = qual_wr && reg_wdata[UECR_EP2_SEL];
   // Alternation overrides the firmware choice while it runs
   assign cur_sel = auto_alt ? auto_sel_b : s_q.sel;

   uecr_stall_bit u_rx_stall (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .fw_set(wr_rx && reg_wdata[UECR_RX_STALL]),
      .hw_set(rx_stall_set),
      .hw_clr(stall_clr),
      .stall_q(rx_stall)
   );

   uecr_stall_bit u_tx_stall (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .fw_set(wr_tx && reg_wdata[UECR_TX_STALL]),
      .hw_set(tx_stall_set),
      .hw_clr(stall_clr),
      .stall_q(tx_stall)
   );

   uecr_fill_count u_cnt_a (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .clr(clr_a),
      .byte_in(buf_byte && !cur_sel),
      .count_q(buf_a_count)
   );

   uecr_fill_count u_cnt_b (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .clr(clr_b),
      .byte_in(buf_byte && cur_sel),
      .count_q(buf_b_count)
   );

   // Next state of control bits, read port and handshake choice
   always_comb
   begin
      s_d = s_q;
      s_d.hs_v = 1'b0;
      s_d.err = 1'b0;
      s_d.rdata = 8'h00;
      if (wr_rx)
         s_d.rx_en = reg_wdata[UECR_RX_ENABLE];
      if (rx_data_valid)
         s_d.rx_tog = rx_data_toggle;
      // Firmware arm wins if it lands with a completion
      if (tx_done)
         s_d.tx_arm = 1'b0;
      if (wr_tx && reg_wdata[UECR_TX_ARM])
         s_d.tx_arm = 1'b1;
      if (wr_ep2)
         s_d.dir = reg_wdata[UECR_EP2_DIR];
      if (qual_wr)
         s_d.sel = reg_wdata[UECR_EP2_SEL];
      else if (auto_alt)
         s_d.sel = auto_sel_b; // Keep last filled after alternation stops
      // Reads return data in the next cycle; unmapped reads give zero
      if (reg_rd)
      begin
         unique case (reg_addr)
            UECR_OFS_EP1_RX:
            begin
               s_d.rdata[UECR_RX_ENABLE] = s_q.rx_en;
               s_d.rdata[UECR_RX_STALL] = rx_stall;
               s_d.rdata[UECR_RX_TOGGLE] = s_q.rx_tog;
            end
            UECR_OFS_EP1_TX:
            begin
               s_d.rdata[UECR_TX_ENABLE] = tx_enabled;
               s_d.rdata[UECR_TX_STALL] = tx_stall;
               s_d.rdata[UECR_TX_ARM] = s_q.tx_arm;
            end
            UECR_OFS_EP2:
            begin
               s_d.rdata[UECR_EP2_DIR] = s_q.dir;
               s_d.rdata[UECR_EP2_QUAL] = 1'b0;
               s_d.rdata[UECR_EP2_SEL] = cur_sel;
            end
            default:
               s_d.rdata = 8'h00;
         endcase
      end
      // Token handling: stall outranks NAK, NAK outranks ACK
      if (tok_valid)
      begin
         s_d.hs_v = 1'b1;
         s_d.hs = UECR_HS_ACK;
         if (tok_ep2)
         begin
            if (s_q.dir && !tok_in)
               s_d.err = 1'b1;
            if (!s_q.dir && tok_in)
               s_d.err = 1'b1;
         end
         else if (tok_in)
         begin
            if (tx_stall)
               s_d.hs = UECR_HS_STALL;
         end
         else if (rx_stall)
            s_d.hs = UECR_HS_STALL;
         else if (s_q.tx_arm || !s_q.rx_en)
            s_d.hs = UECR_HS_NAK;
      end
   end

   // State register; everything clears on reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_q <= '0;
      else if (ce)
         s_q <= s_d;
   end

   // Outputs straight from flip-flops
   assign reg_rdata = s_q.rdata;
   assign ep1_rx_enable = s_q.rx_en;
   assign ep1_tx_armed = s_q.tx_arm;
   assign ep2_dir_to_host = s_q.dir;
   assign buf_sel_b = s_q.sel;
   assign hs_valid = s_q.hs_v;
   assign hs_code = s_q.hs;
   assign bulk_direction_error = s_q.err;
endmodule

// File: uecr_regs_asserts.sv
// Port checks of the endpoint control bank
`timescale 1ns/100ps
module uecr_regs_asserts
   import uecr_pkg::*;
(
   input logic clk_sys, // Clock
   input logic rst, // Reset
   input logic [7:0] reg_addr, // Address
   input logic [7:0] reg_wdata, // Write data
   input logic reg_wr, // Write strobe
   input logic reg_rd, // Read strobe
   input logic [7:0] reg_rdata, // Read data
   input logic tx_done, // Packet sent
   input logic tok_valid, // Token seen
   input logic tok_in, // IN token
   input logic tok_ep2, // Endpoint two
   input logic auto_alt, // Alternation on
   input logic auto_sel_b, // Alternation buffer
   input logic ep1_rx_enable, // Reception on
   input logic ep1_tx_armed, // Packet armed
   input logic ep2_dir_to_host, // Bulk direction
   input logic buf_sel_b, // Buffer select
   input logic hs_valid, // Handshake valid
   input logic [1:0] hs_code, // Handshake
   input logic bulk_direction_error, // Direction error
   input logic [UECR_CNT_W-1:0] buf_a_count // Count A
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Register hits
   wire wr_rx = reg_wr && reg_addr == UECR_OFS_EP1_RX;
   wire wr_tx = reg_wr && reg_addr == UECR_OFS_EP1_TX;
   wire wr_b = reg_wr && reg_addr == UECR_OFS_EP2;
   a_rsvd_zero: assert property (reg_rd && reg_addr == UECR_OFS_EP1_TX
      |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3] && !reg_rdata[1])
      else $error("reserved transmit bits read one");
   a_qual_zero: assert property (reg_rd && reg_addr == UECR_OFS_EP2
      |=> !reg_rdata[6]) else $error("qualifier read one");
   a_in_answer: assert property (tok_valid && tok_in && !tok_ep2
      |=> hs_valid && hs_code != UECR_HS_NAK) else $error("bad IN answer");
   a_out_nak: assert property (tok_valid && !tok_in && !tok_ep2
      && ep1_tx_armed |=> hs_valid && hs_code != UECR_HS_ACK)
      else $error("armed OUT acked");
   a_hs_quiet: assert property (!tok_valid |=> !hs_valid)
      else $error("handshake without token");
   a_dir_err: assert property (tok_valid && tok_ep2
      |=> bulk_direction_error == ($past(ep2_dir_to_host) != $past(tok_in)))
      else $error("direction error wrong");
   a_arm_set: assert property (wr_tx && reg_wdata[UECR_TX_ARM]
      |=> ep1_tx_armed) else $error("arm not taken");
   a_arm_clear: assert property (ep1_tx_armed && tx_done && !wr_tx
      |=> !ep1_tx_armed) else $error("arm not cleared");
   a_rx_enable: assert property (wr_rx
      |=> ep1_rx_enable == $past(reg_wdata[UECR_RX_ENABLE]))
      else $error("receive enable wrong");
   a_sel_hold: assert property (wr_b && !reg_wdata[UECR_EP2_QUAL]
      && !auto_alt && !$past(auto_alt) |=> $stable(buf_sel_b))
      else $error("unqualified select taken");
   a_sel_a_clr: assert property (wr_b && reg_wdata[6] && !reg_wdata[5]
      && !auto_alt |=> buf_a_count == UECR_CNT_ZERO && !buf_sel_b)
      else $error("buffer A not selected");
   a_auto_sel: assert property (auto_alt && $past(auto_alt)
      && $stable(auto_sel_b) |-> buf_sel_b == auto_sel_b)
      else $error("select ignores alternation");
endmodule
bind uecr_regs uecr_regs_asserts u_uecr_regs_asserts (.*);

// File: uecr_regs_tb.sv
// Register and token tests of the endpoint control bank
`timescale 1ns/100ps
module uecr_regs_tb;
   import uecr_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
   logic clk_sys = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic bus_reset = 0, clear_feature_ep1 = 0, tx_enabled = 0, tx_done;
   logic rx_stall_set = 0, tx_stall_set = 0, rx_data_valid = 0;
   logic rx_data_toggle = 0, tok_valid = 0, tok_in = 0, tok_ep2 = 0;
   logic auto_alt = 0, auto_sel_b = 0, buf_byte = 0;
   logic ep1_rx_enable, ep1_tx_armed, ep2_dir_to_host, buf_sel_b;
   logic hs_valid, bulk_direction_error;
   logic [1:0] hs_code;
   logic [UECR_CNT_W-1:0] buf_a_count, buf_b_count;
   int bad_count = 0, n_checks = 0, cyc = 0;
   uecr_regs u_uecr_regs (.*);
   uecr_engine_model u_uecr_engine_model (.clk_sys(clk_sys), .rst(rst),
      .ep1_tx_armed(ep1_tx_armed), .tx_done(tx_done));
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Cut a hang short well past the expected run
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         test_done;
      end
   end
   task wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0;
      #1;
   endtask
   // Data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, e);
      @(posedge clk_sys);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 `CHK(reg_rdata, e)
   endtask
   task tok(input logic i, p, input logic [1:0] c, input logic er);
      @(posedge clk_sys);
      tok_valid <= 1;
      tok_in <= i;
      tok_ep2 <= p;
      @(posedge clk_sys);
      tok_valid <= 0;
      #1 `CHK(hs_valid, 1'b1)
      `CHK(hs_code, c)
      `CHK(bulk_direction_error, er)
   endtask
   task bytes(input int n);
      @(posedge clk_sys);
      buf_byte <= 1;
      repeat (n) @(posedge clk_sys);
      buf_byte <= 0;
      #1;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst <= 0;
      rd(UECR_OFS_EP1_RX, 8'h00);
      rd(UECR_OFS_EP1_TX, 8'h00);
      rd(UECR_OFS_EP2, 8'h00);
      wr(8'hB5, 8'hFF);
      rd(8'hB5, 8'h00);
      $display("end reset values");
      wr(UECR_OFS_EP1_RX, 8'hFF);
      rd(UECR_OFS_EP1_RX, 8'h05);
      wr(UECR_OFS_EP1_RX, 8'h00);
      rd(UECR_OFS_EP1_RX, 8'h04);
      tok(0, 0, UECR_HS_STALL, 0);
      clear_feature_ep1 <= 1;
      @(posedge clk_sys) clear_feature_ep1 <= 0;
      rx_data_valid <= 1;
      rx_data_toggle <= 1;
      @(posedge clk_sys) rx_data_valid <= 0;
      rd(UECR_OFS_EP1_RX, 8'h08);
      $display("end receive control");
      tx_enabled <= 1;
      wr(UECR_OFS_EP1_TX, 8'hFF);
      rd(UECR_OFS_EP1_TX, 8'h15);
      tok(1, 0, UECR_HS_STALL, 0);
      bus_reset <= 1;
      @(posedge clk_sys) bus_reset <= 0;
      repeat (10) @(posedge clk_sys);
      rd(UECR_OFS_EP1_TX, 8'h01);
      tx_enabled <= 0;
      rd(UECR_OFS_EP1_TX, 8'h00);
      wr(UECR_OFS_EP1_RX, 8'h01);
      wr(UECR_OFS_EP1_TX, 8'h10);
      tok(0, 0, UECR_HS_NAK, 0);
      repeat (12) @(posedge clk_sys);
      tok(0, 0, UECR_HS_ACK, 0);
      tx_stall_set <= 1;
      rx_stall_set <= 1;
      @(posedge clk_sys) tx_stall_set <= 0;
      rx_stall_set <= 0;
      tok(1, 0, UECR_HS_STALL, 0);
      tok(0, 0, UECR_HS_STALL, 0);
      wr(UECR_OFS_EP1_TX, 8'h00);
      tok(1, 0, UECR_HS_STALL, 0);
      $display("end transmit control");
      wr(UECR_OFS_EP2, 8'hC0);
      rd(UECR_OFS_EP2, 8'h80);
      tok(0, 1, UECR_HS_ACK, 1);
      tok(1, 1, UECR_HS_ACK, 0);
      wr(UECR_OFS_EP2, 8'h00);
      tok(1, 1, UECR_HS_ACK, 1);
      tok(0, 1, UECR_HS_ACK, 0);
      wr(UECR_OFS_EP2, 8'h20);
      rd(UECR_OFS_EP2, 8'h00);
      bytes(3);
      `CHK(buf_a_count, 10'h003)
      wr(UECR_OFS_EP2, 8'h60);
      rd(UECR_OFS_EP2, 8'h20);
      bytes(2);
      `CHK(buf_b_count, 10'h002)
      `CHK(buf_a_count, 10'h003)
      wr(UECR_OFS_EP2, 8'h40);
      `CHK(buf_a_count, 10'h000)
      `CHK(buf_b_count, 10'h002)
      rd(UECR_OFS_EP2, 8'h00);
      auto_alt <= 1;
      auto_sel_b <= 1;
      repeat (3) @(posedge clk_sys);
      rd(UECR_OFS_EP2, 8'h20);
      auto_sel_b <= 0;
      repeat (3) @(posedge clk_sys);
      #1 `CHK(buf_sel_b, 1'b0)
      $display("end bulk control");
      test_done;
   end
endmodule

// File: uecr_stall_bit.sv
// One stall flag: set by engine or firmware, cleared by hardware only
`timescale 1ns/100ps
module uecr_stall_bit
   import uecr_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic ce, // Clock enable
   input wire logic fw_set, // Firmware wrote a one
   input wire logic hw_set, // Engine sets the stall
   input wire logic hw_clr, // Clear feature or bus reset
   output logic stall_q // Stall flag
);
   typedef struct packed {logic stall;} uecr_stb_s;
   uecr_stb_s s_q, s_d;

   // Set wins over clear so an event in the clearing cycle survives
   always_comb
   begin
      s_d = s_q;
      if (hw_clr)
         s_d.stall = 1'b0;
      if (fw_set || hw_set)
         s_d.stall = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_q <= '0;
      else if (ce)
         s_q <= s_d;
   end

   assign stall_q = s_q.stall;
endmodule
